// [dv/hub_port_disable_config_tb.sv]
`timescale 1ns/1ps
module hub_port_disable_config_tb;
  import port_off_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, self_powered, default_config;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [4:1]  port_off_strap_plus, port_off_strap_minus, port_enabled;
  logic [2:0]  port_count;
  logic [12:1] logical_port_num;
  logic        port_remap_select;
  int          fails, checks, cyc;

  hub_port_disable_config DUT (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .self_powered, .default_config,
    .port_off_strap_plus, .port_off_strap_minus, .port_enabled,
    .port_count, .logical_port_num, .port_remap_select);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang costs a mismatch rather than a silent stall
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    cmp(20'(reg_rdata), 20'(exp));
  endtask

  // Expected view worked out from the mask: dense numbers, ascending
  task automatic chk_ports(input logic [7:0] m);
    logic [12:1] num;
    logic [2:0]  n;
    n   = 3'h0;
    num = 12'h000;
    for (int i = 1; i <= 4; i++) begin
      if (!m[i]) begin
        n++;
        num[3*i -: 3] = n;
      end
    end
    repeat (3) @(posedge clk);
    #1;
    cmp({1'b0, port_enabled, port_count, logical_port_num},
        {1'b0, ~m[4:1], n, num});
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, default_config} = '0;
    {port_off_strap_plus, port_off_strap_minus} = '0;
    self_powered = 1'b1;
    {cyc, fails, checks} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk_ports(8'h00);
    $display("test reset done");
    wr(OFF_SELF_POWER_PORT_OFF, 8'hff);
    rd(OFF_SELF_POWER_PORT_OFF, 8'h1e);
    chk_ports(8'hff);
    wr(OFF_SELF_POWER_PORT_OFF, 8'h04);
    chk_ports(8'h04);
    $display("test self mask done");
    wr(OFF_BUS_POWER_PORT_OFF, 8'h12);
    self_powered <= 1'b0;
    chk_ports(8'h12);
    rd(OFF_BUS_POWER_PORT_OFF, 8'h12);
    self_powered <= 1'b1;
    chk_ports(8'h04);
    $display("test power switch done");
    default_config       <= 1'b1;
    port_off_strap_plus  <= 4'h1;
    port_off_strap_minus <= 4'h8;
    chk_ports(8'h12);
    default_config <= 1'b0;
    wr(OFF_REMAP_CTRL, 8'h01);
    chk_ports(8'h00);
    cmp(20'(port_remap_select), 20'h1);
    rd(OFF_REMAP_CTRL, 8'h01);
    $display("test straps and remap done");
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    rd(OFF_SELF_POWER_PORT_OFF, 8'h04);
    rd(OFF_PORT_STATUS, 8'h4f);
    $display("test unmapped done");
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    chk_ports(8'h00);
    rd(OFF_SELF_POWER_PORT_OFF, 8'h00);
    rd(OFF_REMAP_CTRL, 8'h00);
    $display("test reset again done");
    finish_test();
  end
endmodule

// [hw/hub_port_disable_config.sv]
// Notes on behaviour
// - Masks are eight bits; bits 4..1 map to ports 4..1, others reserved.
// - A mask bit of one disables its port; zero leaves it available.
// - Self-powered, standard mode: self-powered mask picks disabled ports.
// - A disabled port is hidden: host cannot enable or enumerate it.
// - Any disable pattern allowed; reported count equals enabled ports.
// - Remaining active ports are renumbered densely in ascending order.
// - Bus-powered mask has the same meaning as the self-powered mask.
// - Under default configuration the strap pins replace the masks.
// - Remap select: zero is standard mode, one is port mapping mode.
`timescale 1ns/1ps
module hub_port_disable_config
  import port_off_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             self_powered,
  input  wire logic             default_config,
  input  wire logic [PORTS:1]   port_off_strap_plus,
  input  wire logic [PORTS:1]   port_off_strap_minus,
  output logic      [PORTS:1]   port_enabled,
  output logic      [2:0]       port_count,
  output logic      [PORTS*3:1] logical_port_num,
  output logic                  port_remap_select
);

  reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [7:0]       self_power_port_off_mask_q;
  logic [7:0]       bus_power_port_off_mask_q;
  logic             remap_q;
  logic [7:0]       rdata_q;
  logic [PORTS:1]   enabled_q;
  logic [2:0]       count_q;
  logic [PORTS*3:1] lnum_q;

  // Address match shared by the write decode and the read select
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] off
  );
    return a == off;
  endfunction

  // Register decode
  wire wr_self  = req.wr && hit(req.addr, OFF_SELF_POWER_PORT_OFF);
  wire wr_bus   = req.wr && hit(req.addr, OFF_BUS_POWER_PORT_OFF);
  wire wr_remap = req.wr && hit(req.addr, OFF_REMAP_CTRL);

  // Reserved bits are not stored, so they always read back zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_power_port_off_mask_q <= RST_PORT_OFF;
      bus_power_port_off_mask_q  <= RST_PORT_OFF;
      remap_q                    <= RST_REMAP;
    end else begin
      if (wr_self)
        self_power_port_off_mask_q <= req.wdata & MASK_VALID;
      if (wr_bus)
        bus_power_port_off_mask_q <= req.wdata & MASK_VALID;
      if (wr_remap)
        remap_q <= req.wdata[REMAP_BIT];
    end
  end

  remap_mode_t mode;
  assign mode = remap_q ? MODE_REMAP : MODE_STANDARD;

  // Mask selection follows the current power source without latching
  wire [7:0] sw_mask = self_powered ? self_power_port_off_mask_q
                                    : bus_power_port_off_mask_q;
  // Either strap of a pair disables the port
  wire [PORTS:1] strap_off = port_off_strap_plus | port_off_strap_minus;
  // Remap mode disables nothing here; its mapping lives elsewhere
  wire [PORTS:1] off_sel = default_config ? strap_off
                         : (mode == MODE_STANDARD) ? sw_mask[PORTS:1]
                         : '0;
  wire [PORTS:1] en_d = ~off_sel;

  // Dense renumbering: logical number is one plus enabled ports below
  logic [PORTS*3:1] lnum_d;
  logic [2:0]       cnt_d;
  always_comb begin
    logic [2:0] run;
    run = 3'h0;
    lnum_d = '0;
    for (int i = 1; i <= PORTS; i++) begin
      if (en_d[i]) begin
        run = run + 3'h1;
        lnum_d[(i-1)*3+1 +: 3] = run;
      end
    end
    cnt_d = run;
  end

  wire [7:0] status = {1'b0, cnt_d, en_d};

  // Unmapped addresses read zero so software can probe safely
  wire [7:0] rd_mux =
    hit(req.addr, OFF_SELF_POWER_PORT_OFF) ? self_power_port_off_mask_q :
    hit(req.addr, OFF_BUS_POWER_PORT_OFF)  ? bus_power_port_off_mask_q  :
    hit(req.addr, OFF_REMAP_CTRL)          ? {7'h00, remap_q}           :
    hit(req.addr, OFF_PORT_STATUS)         ? status                     :
    8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q   <= 8'h00;
      enabled_q <= '0;
      count_q   <= 3'h0;
      lnum_q    <= '0;
    end else begin
      rdata_q   <= req.rd ? rd_mux : 8'h00;
      enabled_q <= en_d;
      count_q   <= cnt_d;
      lnum_q    <= lnum_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign port_enabled      = enabled_q;
  assign port_count        = count_q;
  assign logical_port_num  = lnum_q;
  assign port_remap_select = remap_q;

  chk_mask_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (self_power_port_off_mask_q & ~MASK_VALID) == 8'h00 &&
    (bus_power_port_off_mask_q & ~MASK_VALID) == 8'h00)
    else $error("reserved mask bit set");

  chk_write_self: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_self
    |=> self_power_port_off_mask_q == ($past(reg_wdata) & MASK_VALID))
    else $error("self mask write lost");

  chk_write_bus: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_bus
    |=> bus_power_port_off_mask_q == ($past(reg_wdata) & MASK_VALID))
    else $error("bus mask write lost");

  chk_hold_self: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_self |=> $stable(self_power_port_off_mask_q))
    else $error("self mask changed without write");

  chk_hold_bus: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_bus |=> $stable(bus_power_port_off_mask_q))
    else $error("bus mask changed without write");

  chk_self_mask_used: assert property (
    @(posedge clk) disable iff (!rst_n)
    !default_config && self_powered && !remap_q
    |=> port_enabled == ~$past(self_power_port_off_mask_q[PORTS:1]))
    else $error("self mask not applied");

  chk_bus_mask_used: assert property (
    @(posedge clk) disable iff (!rst_n)
    !default_config && !self_powered && !remap_q
    |=> port_enabled == ~$past(bus_power_port_off_mask_q[PORTS:1]))
    else $error("bus mask not applied");

  chk_strap_used: assert property (
    @(posedge clk) disable iff (!rst_n)
    default_config |=> port_enabled ==
      ~($past(port_off_strap_plus) | $past(port_off_strap_minus)))
    else $error("straps not applied");

  chk_remap_all_on: assert property (
    @(posedge clk) disable iff (!rst_n)
    !default_config && remap_q |=> &port_enabled)
    else $error("remap mode disabled a port");

  chk_count_match: assert property (
    @(posedge clk) disable iff (!rst_n)
    port_count == 3'($countones(port_enabled)))
    else $error("port count mismatch");

  chk_count_range: assert property (
    @(posedge clk) disable iff (!rst_n)
    port_count <= PORTS)
    else $error("port count out of range");

  chk_disabled_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !port_enabled[1] |-> logical_port_num[3:1] == 3'h0)
    else $error("disabled port numbered");

  chk_renum_first: assert property (
    @(posedge clk) disable iff (!rst_n)
    port_enabled[1] |-> logical_port_num[3:1] == 3'h1)
    else $error("port 1 numbering wrong");

  chk_renum_last: assert property (
    @(posedge clk) disable iff (!rst_n)
    port_enabled[PORTS] |-> logical_port_num[PORTS*3 -: 3] == port_count)
    else $error("last port numbering wrong");

  // Every physical port checked on its own field
  for (genvar g = 1; g <= PORTS; g++) begin : g_port_chk
    chk_port_off_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      !port_enabled[g] |-> logical_port_num[3*g -: 3] == 3'h0)
      else $error("disabled port carries a number");

    chk_port_dense: assert property (
      @(posedge clk) disable iff (!rst_n)
      port_enabled[g]
      |-> logical_port_num[3*g -: 3] == 3'($countones(port_enabled[g:1])))
      else $error("port number not dense");
  end

  chk_remap_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_remap |=> port_remap_select == $past(reg_wdata[REMAP_BIT]))
    else $error("remap select not written");

  chk_read_mask: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_SELF_POWER_PORT_OFF
    |=> reg_rdata == $past(self_power_port_off_mask_q))
    else $error("mask readback wrong");

  chk_read_bus_mask: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_BUS_POWER_PORT_OFF
    |=> reg_rdata == $past(bus_power_port_off_mask_q))
    else $error("bus mask readback wrong");

  chk_read_remap: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_REMAP_CTRL
    |=> reg_rdata == {7'h00, port_remap_select})
    else $error("remap readback wrong");

  // Status and port outputs come from the same cycle's decode
  chk_read_status: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_PORT_STATUS
    |=> reg_rdata == {1'b0, port_count, port_enabled})
    else $error("status readback wrong");

  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

endmodule

// [hw/port_off_pkg.sv]
package port_off_pkg;

  localparam int unsigned NUM_PORTS   = 4;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;

  // Register offsets
  localparam logic [7:0] OFF_SELF_POWER_PORT_OFF = 8'h0a;
  localparam logic [7:0] OFF_BUS_POWER_PORT_OFF  = 8'h0b;
  localparam logic [7:0] OFF_REMAP_CTRL          = 8'h20;
  localparam logic [7:0] OFF_PORT_STATUS         = 8'h21;

  // Field layout of the masks
  localparam int unsigned PORT_LSB    = 1;
  localparam int unsigned PORT_MSB    = 4;
  localparam logic [7:0]  MASK_VALID  = 8'h1e;

  // Remap control field
  localparam int unsigned REMAP_BIT   = 0;

  // Reset values
  localparam logic [7:0] RST_PORT_OFF = 8'h00;
  localparam logic       RST_REMAP    = 1'b0;

  typedef enum logic {
    MODE_STANDARD,
    MODE_REMAP
  } remap_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] enabled;
    logic [2:0] count;
  } port_view_t;

endpackage
